// >>> design/rbsl_page_map.sv
`timescale 1ns/1ps
module rbsl_page_map
    import rbsl_pkg::*;
#(
    parameter bit BIG_DEVICE = 1'b1
) (
    input wire logic [15:0] addr,
    input wire logic [RBSL_NUM_PAGES-1:0] page_lock,
    output logic internal,
    output logic locked
);
    localparam logic [15:0] PRIM = BIG_DEVICE ? RBSL_PRIM_BIG : RBSL_PRIM_SMALL;
    logic [2:0] page;

    // four primary pages, secondary page above
    always_comb begin
        internal = addr < (PRIM + RBSL_SEC_SIZE);
        if (addr >= PRIM) begin
            page = 3'(RBSL_SEC_PAGE);
        end else if (BIG_DEVICE) begin
            page = {1'b0, addr[13:12]};
        end else begin
            page = {1'b0, addr[12:11]};
        end
        locked = internal && page_lock[page];
    end
endmodule

// >>> design/rbsl_pkg.sv
package rbsl_pkg;
    // register byte offsets
    localparam logic [7:0] RBSL_OFF_CMD = 8'h00;
    localparam logic [7:0] RBSL_OFF_STATUS = 8'h04;
    localparam logic [7:0] RBSL_OFF_BOOT = 8'h08;
    localparam logic [7:0] RBSL_OFF_POWER_CTRL = 8'h0c;
    localparam logic [7:0] RBSL_OFF_DATA = 8'h10;
    // command opcodes, in cmd[3:0]
    localparam logic [3:0] RBSL_OP_NOP = 4'h0;
    localparam logic [3:0] RBSL_OP_CHIP_ERASE = 4'h1;
    localparam logic [3:0] RBSL_OP_PRIMARY_ERASE = 4'h2;
    localparam logic [3:0] RBSL_OP_IDENTITY_READ = 4'h3;
    localparam logic [3:0] RBSL_OP_READ = 4'h4;
    localparam logic [3:0] RBSL_OP_CHIP_LOCK = 4'h5;
    localparam logic [3:0] RBSL_OP_PAGE_SECURE = 4'h6;
    localparam logic [3:0] RBSL_OP_SET_USER_VECTOR = 4'h7;
    localparam logic [3:0] RBSL_OP_SET_BOOT_BITS = 4'h8;
    // command field positions
    localparam int RBSL_CMD_SELF_BIT = 4;
    localparam int RBSL_CMD_EXT_BIT = 5;
    localparam int RBSL_CMD_PEND_BIT = 7;
    localparam int RBSL_CMD_ARG_LSB = 8;
    localparam int RBSL_CMD_ADDR_LSB = 16;
    // chip lock indexes
    localparam int RBSL_LK_CODE_READ = 0;
    localparam int RBSL_LK_HOST = 1;
    localparam int RBSL_LK_INT_BOOT = 2;
    localparam int RBSL_LK_SELF_PROG = 3;
    localparam int RBSL_NUM_PAGES = 5;
    localparam int RBSL_SEC_PAGE = 4;
    localparam logic [4:0] RBSL_PRIMARY_PAGES = 5'h0f;
    // status field positions
    localparam int RBSL_ST_PAGE_LSB = 4;
    localparam int RBSL_ST_FORCED_BIT = 9;
    localparam int RBSL_ST_POF_BIT = 10;
    localparam int RBSL_ST_USER_BIT = 11;
    localparam int RBSL_ST_ZERO_BIT = 12;
    localparam int RBSL_ST_REFUSED_BIT = 13;
    localparam int RBSL_ST_VEC_LSB = 16;
    localparam int RBSL_POF_BIT = 0;
    // read-back values for locked areas
    localparam logic [7:0] RBSL_HOST_LOCKED = 8'h55;
    localparam logic [7:0] RBSL_TABLE_LOCKED = 8'h00;
    // reset pin hold, in clocks
    localparam int RBSL_RST_HOLD_CLOCKS = 24;
    localparam logic [15:0] RBSL_ZERO_ADDR = 16'h0000;
    localparam logic [15:0] RBSL_SEC_SIZE = 16'h0400;
    localparam logic [15:0] RBSL_PRIM_BIG = 16'h4000;
    localparam logic [15:0] RBSL_PRIM_SMALL = 16'h2000;
    localparam logic [1:0] RBSL_RESP_OKAY = 2'h0;
    localparam logic [1:0] RBSL_RESP_SLVERR = 2'h2;
    // factory value of boot control bits
    localparam logic RBSL_BOOT_BIT_FACTORY = 1'b1;
endpackage

// >>> design/rbsl_sync2.sv
`timescale 1ns/1ps
module rbsl_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    // first stage read by the second only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// >>> design/rbsl_top.sv
`timescale 1ns/1ps
module rbsl_top
    import rbsl_pkg::*;
#(
    parameter bit BIG_DEVICE = 1'b1,
    parameter int ADDR_W = 8,
    parameter logic [15:0] DEFAULT_BOOT_VECTOR = 16'h2000,
    parameter logic [7:0] IDENTITY_CODE = 8'ha6 // value is arbitrary
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    // reset pin, straps and external access pin from the board
    input wire logic RST_PIN,
    input wire logic STRAP_PIN_A,
    input wire logic STRAP_PIN_B,
    input wire logic EXTERNAL_ACCESS_PIN_N,
    // core strobes and their pads
    input wire logic CORE_ALE,
    input wire logic CORE_PROGRAM_STORE_STROBE_N,
    output logic ALE_O,
    output logic ALE_OE,
    output logic PROGRAM_STORE_STROBE_N_O,
    output logic PROGRAM_STORE_STROBE_N_OE,
    output logic STROBE_PULLUP_EN,
    // reset and start to the core
    output logic SFR_RESET,
    output logic FETCH_START,
    output logic [15:0] BOOT_ADDR,
    // code-table read port
    input wire logic CODE_TABLE_READ_REQ,
    input wire logic [15:0] CODE_TABLE_READ_ADDR,
    input wire logic CODE_TABLE_READ_FROM_EXT,
    output logic CODE_TABLE_READ_BUSY,
    output logic CODE_TABLE_READ_VALID,
    output logic [7:0] CODE_TABLE_READ_DATA,
    // flash array, read combinationally from FLASH_ADDR
    output logic [15:0] FLASH_ADDR,
    input wire logic [7:0] FLASH_Q,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    initial begin
        if (ADDR_W < 5 || ADDR_W > 8) begin
            $error("ADDR_W must be 5 to 8");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        RBSL_IDLE = 3'b001,
        RBSL_TABLE = 3'b010,
        RBSL_CMD_RD = 3'b100
    } rbsl_fsm_t;

    typedef struct packed {
        rbsl_fsm_t fsm;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [4:0] rst_cnt;
        logic rst_valid;
        logic por_pending;
        logic [3:0] chip_lock;
        logic [RBSL_NUM_PAGES-1:0] page_lock;
        logic boot_user;
        logic boot_zero;
        logic [7:0] user_vec;
        logic forced_flag;
        logic power_on_flag;
        logic [15:0] boot_addr;
        logic fetch_start;
        logic cmd_pending;
        logic [3:0] cmd_op;
        logic cmd_self;
        logic cmd_ext;
        logic [7:0] cmd_arg;
        logic [15:0] cmd_addr;
        logic refused;
        logic [7:0] flash_data;
        logic [7:0] host_data;
        logic [15:0] flash_addr;
        logic table_ext;
        logic table_valid;
        logic [7:0] table_data;
        logic ale_o;
        logic ale_oe;
        logic program_store_strobe_o;
        logic program_store_strobe_oe;
        logic pullup_en;
        logic sfr_reset;
    } rbsl_state_t;

    rbsl_state_t s_reg;
    rbsl_state_t s_next;

    ////////////////////////////////////////////////////////////////////////////
    // pins synced; reset reads held until settled, so no boot on stale pins
    logic [3:0] pins_s;
    logic rst_s;
    logic strap_a_s;
    logic strap_b_s;
    logic ext_n_s;

    rbsl_sync2 #(.WIDTH(4), .RST_VAL(4'h1)) u_sync (
        .clk(REF_CLK),
        .rst_n(NRST),
        .d({EXTERNAL_ACCESS_PIN_N, STRAP_PIN_B, STRAP_PIN_A, RST_PIN}),
        .q(pins_s)
    );
    assign {ext_n_s, strap_b_s, strap_a_s, rst_s} = pins_s;

    logic addr_internal;
    logic addr_locked;

    rbsl_page_map #(.BIG_DEVICE(BIG_DEVICE)) u_map (
        .addr(s_reg.flash_addr),
        .page_lock(s_reg.page_lock),
        .internal(addr_internal),
        .locked(addr_locked)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] user_addr;
    logic [15:0] vector_addr;
    logic [15:0] boot_pick;
    logic straps_low;
    logic boot_now;
    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [31:0] rd_word;
    logic rd_hit;
    logic allowed;

    // vector placement by flash size
    assign user_addr = BIG_DEVICE ? {2'h0, s_reg.user_vec, 6'h00}
                                  : {3'h0, s_reg.user_vec, 5'h00};
    assign vector_addr = s_reg.boot_user ? DEFAULT_BOOT_VECTOR : user_addr;
    assign straps_low = !strap_a_s && !strap_b_s;

    // boot choice at reset exit
    always_comb begin
        if (!ext_n_s && !s_reg.chip_lock[RBSL_LK_INT_BOOT]) begin
            boot_pick = RBSL_ZERO_ADDR;
        end else if (straps_low) begin
            boot_pick = vector_addr;
        end else if (!s_reg.boot_zero) begin
            boot_pick = RBSL_ZERO_ADDR;
        end else begin
            boot_pick = vector_addr;
        end
    end

    // a pulse shorter than the hold time is not a reset
    assign boot_now = (s_reg.rst_valid || s_reg.por_pending) && !rst_s;

    // register read mux
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        case (ARADDR)
            ADDR_W'(RBSL_OFF_CMD): begin
                rd_word = {s_reg.cmd_addr, s_reg.cmd_arg, s_reg.cmd_pending, 1'b0, s_reg.cmd_ext,
                           s_reg.cmd_self, s_reg.cmd_op};
            end
            ADDR_W'(RBSL_OFF_STATUS): begin
                rd_word[3:0] = s_reg.chip_lock;
                rd_word[RBSL_ST_PAGE_LSB +: RBSL_NUM_PAGES] = s_reg.page_lock;
                rd_word[RBSL_ST_FORCED_BIT] = s_reg.forced_flag;
                rd_word[RBSL_ST_POF_BIT] = s_reg.power_on_flag;
                rd_word[RBSL_ST_USER_BIT] = s_reg.boot_user;
                rd_word[RBSL_ST_ZERO_BIT] = s_reg.boot_zero;
                rd_word[RBSL_ST_REFUSED_BIT] = s_reg.refused;
                rd_word[RBSL_ST_VEC_LSB +: 8] = s_reg.user_vec;
            end
            ADDR_W'(RBSL_OFF_BOOT): rd_word = {16'h0000, s_reg.boot_addr};
            ADDR_W'(RBSL_OFF_POWER_CTRL): rd_word[RBSL_POF_BIT] = s_reg.power_on_flag;
            ADDR_W'(RBSL_OFF_DATA): rd_word = {16'h0000, s_reg.host_data, s_reg.flash_data};
            default: rd_hit = 1'b0;
        endcase
    end

    // byte lanes of the buffered write
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{s_reg.w_strb[i]}};
        end
    end
    assign wval = s_reg.w_data & wmask;
    assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

    // lock filters for host and remote commands
    always_comb begin
        allowed = 1'b1;
        if (!s_reg.cmd_self && s_reg.chip_lock[RBSL_LK_HOST] && s_reg.cmd_op != RBSL_OP_CHIP_ERASE
            && s_reg.cmd_op != RBSL_OP_IDENTITY_READ) begin
            allowed = 1'b0;
        end
        if (s_reg.cmd_self && s_reg.cmd_ext && s_reg.chip_lock[RBSL_LK_SELF_PROG]
            && s_reg.cmd_op != RBSL_OP_CHIP_ERASE) begin
            allowed = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.fetch_start = 1'b0;
        s_next.table_valid = 1'b0;

        // AXI write channels, taken in either order
        if (AWVALID && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = 8'(AWADDR);
        end
        if (WVALID && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.w_data = WDATA;
            s_next.w_strb = WSTRB;
        end
        if (s_reg.bvalid && BREADY) begin
            s_next.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RBSL_RESP_OKAY;
            case (s_reg.aw_addr[ADDR_W-1:0])
                ADDR_W'(RBSL_OFF_CMD): begin
                    // dropped while one is pending
                    if (!s_reg.cmd_pending) begin
                        s_next.cmd_pending = 1'b1;
                        s_next.cmd_op = wval[3:0];
                        s_next.cmd_self = wval[RBSL_CMD_SELF_BIT];
                        s_next.cmd_ext = wval[RBSL_CMD_EXT_BIT];
                        s_next.cmd_arg = wval[RBSL_CMD_ARG_LSB +: 8];
                        s_next.cmd_addr = wval[RBSL_CMD_ADDR_LSB +: 16];
                    end
                end
                ADDR_W'(RBSL_OFF_POWER_CTRL): begin
                    if (s_reg.w_strb[0] && !s_reg.w_data[RBSL_POF_BIT]) begin
                        s_next.power_on_flag = 1'b0;
                    end
                end
                ADDR_W'(RBSL_OFF_STATUS), ADDR_W'(RBSL_OFF_BOOT), ADDR_W'(RBSL_OFF_DATA): begin
                end
                default: s_next.bresp = RBSL_RESP_SLVERR;
            endcase
        end
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;

        // AXI read channel, one word in flight
        if (s_reg.rvalid && RREADY) begin
            s_next.rvalid = 1'b0;
        end
        if (ARVALID && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_word;
            s_next.rresp = rd_hit ? RBSL_RESP_OKAY : RBSL_RESP_SLVERR;
        end
        s_next.arready = !s_next.rvalid;

        // pin reset leaves lock and boot bits alone
        if (rst_s) begin
            if (s_reg.rst_cnt < 5'(RBSL_RST_HOLD_CLOCKS - 1)) begin
                s_next.rst_cnt = s_reg.rst_cnt + 5'h01;
            end else begin
                s_next.rst_valid = 1'b1;
            end
        end else begin
            s_next.rst_cnt = 5'h00;
        end
        if (boot_now) begin
            s_next.rst_valid = 1'b0;
            s_next.por_pending = 1'b0;
            s_next.boot_addr = boot_pick;
            s_next.fetch_start = 1'b1;
            s_next.forced_flag = straps_low;
        end
        s_next.sfr_reset = s_next.rst_valid || s_next.por_pending;

        // strobes float on weak pull-ups while in reset
        s_next.pullup_en = s_next.sfr_reset;
        s_next.ale_oe = !s_next.sfr_reset;
        s_next.program_store_strobe_oe = !s_next.sfr_reset;
        s_next.ale_o = s_next.sfr_reset ? 1'b1 : CORE_ALE;
        s_next.program_store_strobe_o = s_next.sfr_reset ? 1'b1 : CORE_PROGRAM_STORE_STROBE_N;

        // flash access sequencer; table reads win over commands
        case (s_reg.fsm)
            RBSL_IDLE: begin
                if (CODE_TABLE_READ_REQ) begin
                    s_next.flash_addr = CODE_TABLE_READ_ADDR;
                    s_next.table_ext = CODE_TABLE_READ_FROM_EXT;
                    s_next.fsm = RBSL_TABLE;
                end else if (s_reg.cmd_pending) begin
                    s_next.cmd_pending = 1'b0;
                    s_next.refused = !allowed;
                    if (allowed) begin
                        case (s_reg.cmd_op)
                            RBSL_OP_CHIP_ERASE: begin
                                s_next.chip_lock = 4'h0;
                                s_next.page_lock = '0;
                                s_next.boot_user = RBSL_BOOT_BIT_FACTORY;
                                s_next.boot_zero = RBSL_BOOT_BIT_FACTORY;
                                s_next.user_vec = 8'h00;
                            end
                            RBSL_OP_PRIMARY_ERASE: begin
                                s_next.page_lock = s_reg.page_lock & ~RBSL_PRIMARY_PAGES;
                            end
                            RBSL_OP_IDENTITY_READ: s_next.host_data = IDENTITY_CODE;
                            RBSL_OP_READ: begin
                                s_next.flash_addr = s_reg.cmd_addr;
                                s_next.fsm = RBSL_CMD_RD;
                            end
                            RBSL_OP_CHIP_LOCK: s_next.chip_lock[s_reg.cmd_arg[1:0]] = 1'b1;
                            RBSL_OP_PAGE_SECURE: begin
                                if (s_reg.cmd_arg[2:0] < 3'(RBSL_NUM_PAGES)) begin
                                    s_next.page_lock[s_reg.cmd_arg[2:0]] = 1'b1;
                                end
                            end
                            RBSL_OP_SET_USER_VECTOR: s_next.user_vec = s_reg.cmd_arg;
                            RBSL_OP_SET_BOOT_BITS: begin
                                s_next.boot_user = s_reg.cmd_arg[0];
                                s_next.boot_zero = s_reg.cmd_arg[1];
                            end
                            default: s_next.refused = 1'b0;
                        endcase
                    end
                end
            end
            RBSL_TABLE: begin
                s_next.table_valid = 1'b1;
                if (!addr_internal || addr_locked
                    || (s_reg.table_ext && s_reg.chip_lock[RBSL_LK_CODE_READ])) begin
                    s_next.table_data = RBSL_TABLE_LOCKED;
                end else begin
                    s_next.table_data = FLASH_Q;
                end
                s_next.fsm = RBSL_IDLE;
            end
            RBSL_CMD_RD: begin
                if (s_reg.cmd_self) begin
                    // locked: data reg kept
                    if (!addr_locked) begin
                        s_next.flash_data = FLASH_Q;
                    end
                end else begin
                    s_next.host_data = addr_locked ? RBSL_HOST_LOCKED : FLASH_Q;
                end
                s_next.fsm = RBSL_IDLE;
            end
            default: s_next.fsm = RBSL_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-up state; lock bits stand in for non-volatile cells
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            s_reg <= '0;
            s_reg.fsm <= RBSL_IDLE;
            s_reg.por_pending <= 1'b1;
            s_reg.sfr_reset <= 1'b1;
            s_reg.pullup_en <= 1'b1;
            s_reg.ale_o <= 1'b1;
            s_reg.program_store_strobe_o <= 1'b1;
            s_reg.power_on_flag <= 1'b1;
            s_reg.boot_user <= RBSL_BOOT_BIT_FACTORY;
            s_reg.boot_zero <= RBSL_BOOT_BIT_FACTORY;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flops, except CODE_TABLE_READ_BUSY decoded from fsm
    assign AWREADY = s_reg.awready;
    assign WREADY = s_reg.wready;
    assign BVALID = s_reg.bvalid;
    assign BRESP = s_reg.bresp;
    assign ARREADY = s_reg.arready;
    assign RVALID = s_reg.rvalid;
    assign RDATA = s_reg.rdata;
    assign RRESP = s_reg.rresp;
    assign SFR_RESET = s_reg.sfr_reset;
    assign FETCH_START = s_reg.fetch_start;
    assign BOOT_ADDR = s_reg.boot_addr;
    assign ALE_O = s_reg.ale_o;
    assign ALE_OE = s_reg.ale_oe;
    assign PROGRAM_STORE_STROBE_N_O = s_reg.program_store_strobe_o;
    assign PROGRAM_STORE_STROBE_N_OE = s_reg.program_store_strobe_oe;
    assign STROBE_PULLUP_EN = s_reg.pullup_en;
    assign FLASH_ADDR = s_reg.flash_addr;
    assign CODE_TABLE_READ_VALID = s_reg.table_valid;
    assign CODE_TABLE_READ_DATA = s_reg.table_data;
    assign CODE_TABLE_READ_BUSY = (s_reg.fsm != RBSL_IDLE);
endmodule

// >>> dv/rbsl_chk.sv
`timescale 1ns/1ps
module rbsl_chk (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic SFR_RESET,
    input wire logic STROBE_PULLUP_EN,
    input wire logic ALE_O,
    input wire logic ALE_OE,
    input wire logic FETCH_START,
    input wire logic [15:0] BOOT_ADDR,
    input wire logic CODE_TABLE_READ_REQ,
    input wire logic CODE_TABLE_READ_BUSY,
    input wire logic CODE_TABLE_READ_VALID,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA
);
    // one domain, NRST masks all
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////////
    // reset and boot
    property p_pull; SFR_RESET && $past(SFR_RESET) |-> STROBE_PULLUP_EN && ALE_O && !ALE_OE; endproperty
    a_pull: assert property (p_pull) else $error("strobes not high in reset");
    property p_start; FETCH_START |-> $past(SFR_RESET) && !SFR_RESET; endproperty
    a_start: assert property (p_start) else $error("start without reset exit");
    property p_pulse; FETCH_START |=> !FETCH_START; endproperty
    a_pulse: assert property (p_pulse) else $error("start pulse too long");
    property p_hold; !SFR_RESET && !FETCH_START |-> $stable(BOOT_ADDR); endproperty
    a_hold: assert property (p_hold) else $error("boot address moved");
    property p_align; FETCH_START |-> BOOT_ADDR[4:0] == 5'h0 && BOOT_ADDR[15:14] == 2'h0; endproperty
    a_align: assert property (p_align) else $error("boot address has stray bits");
    ////////////////////////////////////////////////////////////////////////
    // table read and bus answers
    property p_table;
        CODE_TABLE_READ_REQ && !CODE_TABLE_READ_BUSY |=> CODE_TABLE_READ_BUSY ##1 CODE_TABLE_READ_VALID;
    endproperty
    a_table: assert property (p_table) else $error("table read answer late");
    property p_bhold; BVALID && !BREADY |=> BVALID; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
endmodule
////////////////////////////////////////////////////////////////////////
bind rbsl_top rbsl_chk i_chk (.*);

// >>> dv/rbsl_flash_mdl.sv
`timescale 1ns/1ps
module rbsl_flash_mdl (
    input wire logic [15:0] flash_addr,
    output logic [7:0] flash_q
);
    // byte from address: predictable, no storage
    assign flash_q = flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3c;
endmodule

// >>> dv/reset_boot_and_security_lock_tb_top.sv
`timescale 1ns/1ps
module reset_boot_and_security_lock_tb_top
    import rbsl_pkg::*;
;
    localparam logic [15:0] DV = 16'h2000;
    localparam logic [7:0] ID = 8'h5b; // value is arbitrary
    logic REF_CLK = '0, NRST = '0, RST_PIN = '0, STRAP_PIN_A = '1, STRAP_PIN_B = '1, EXTERNAL_ACCESS_PIN_N = '1;
    logic CORE_ALE = '0, CORE_PROGRAM_STORE_STROBE_N = '1, CODE_TABLE_READ_REQ = '0, CODE_TABLE_READ_FROM_EXT = '0;
    logic AWVALID = '0, WVALID = '0, BREADY = '0, ARVALID = '0, RREADY = '0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [7:0] AWADDR = '0, ARADDR = '0, FLASH_Q, CODE_TABLE_READ_DATA, v, tq[$];
    logic [15:0] CODE_TABLE_READ_ADDR = '0, BOOT_ADDR, FLASH_ADDR, a, bq[$];
    logic [31:0] WDATA = '0, RDATA;
    logic [3:0] WSTRB = 4'hf;
    logic [1:0] BRESP, RRESP;
    logic ALE_O, ALE_OE, PROGRAM_STORE_STROBE_N_O, PROGRAM_STORE_STROBE_N_OE, STROBE_PULLUP_EN, SFR_RESET, FETCH_START;
    logic CODE_TABLE_READ_BUSY, CODE_TABLE_READ_VALID;
    logic [65:0] m, rq[$];
    int bad_count = 0, checks = 0, seed = 32'h59c56aa4;
    rbsl_top #(.DEFAULT_BOOT_VECTOR(DV), .IDENTITY_CODE(ID)) i_dut (.*);
    rbsl_flash_mdl i_flash (.flash_addr(FLASH_ADDR), .flash_q(FLASH_Q));
    always #4 REF_CLK = ~REF_CLK;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] fq(logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h3c;
    endfunction
    task automatic chk(logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: %h not %h", $time, s, e);
        end
    endtask
    // aw and w offered together
    task automatic wr(logic [7:0] ad, logic [31:0] d);
        bit aw = 0, w = 0;
        AWADDR <= ad;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        do begin
            @(posedge REF_CLK);
            aw |= AWREADY;
            w |= WREADY;
            AWVALID <= !aw;
            WVALID <= !w;
        end while (!(aw && w));
        @(posedge REF_CLK);
        BREADY <= 1'b1;
        do @(posedge REF_CLK); while (!BVALID);
        BREADY <= 1'b0;
    endtask
    // late ready, slave must hold
    task automatic rd(logic [7:0] ad, logic [65:0] e);
        rq.push_back(e);
        ARADDR <= ad;
        ARVALID <= 1'b1;
        do @(posedge REF_CLK); while (!ARREADY);
        ARVALID <= 1'b0;
        @(posedge REF_CLK);
        RREADY <= 1'b1;
        do @(posedge REF_CLK); while (!RVALID);
        RREADY <= 1'b0;
    endtask
    task automatic cmd(logic [3:0] op, logic [7:0] arg, logic [15:0] ad = 0, logic [1:0] src = 0);
        wr(RBSL_OFF_CMD, {ad, arg, 2'b00, src, op});
        repeat (6) @(posedge REF_CLK);
    endtask
    task automatic tbl(logic [15:0] ad, logic ext, logic [7:0] e);
        tq.push_back(e);
        CODE_TABLE_READ_REQ <= 1'b1;
        CODE_TABLE_READ_ADDR <= ad;
        CODE_TABLE_READ_FROM_EXT <= ext;
        do @(posedge REF_CLK); while (CODE_TABLE_READ_BUSY);
        CODE_TABLE_READ_REQ <= 1'b0;
        repeat (2) @(posedge REF_CLK);
    endtask
    // pin reset; short pulse must not boot
    task automatic prst(int n, logic [15:0] e);
        if (n > 24) bq.push_back(e);
        RST_PIN <= 1'b1;
        repeat (n) @(posedge REF_CLK);
        RST_PIN <= 1'b0;
        repeat (10) @(posedge REF_CLK);
    endtask
    task automatic complete_run();
        $display("checks %0d, bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // oldest note vs each result
    always @(posedge REF_CLK) begin
        if (RVALID === 1'b1 && RREADY === 1'b1) begin
            m = rq.pop_front();
            chk(RDATA & m[63:32], m[31:0]);
            chk(32'(RRESP), 32'(m[65:64]));
        end
        if (CODE_TABLE_READ_VALID === 1'b1)
            chk(32'(CODE_TABLE_READ_DATA), 32'(tq.pop_front()));
        if (FETCH_START === 1'b1)
            chk(32'(BOOT_ADDR), bq.size() ? 32'(bq.pop_front()) : 32'hffffffff);
    end
    initial begin
        repeat (20000) @(posedge REF_CLK);
        bad_count++;
        complete_run();
    end
    initial begin
        bq.push_back(DV);
        repeat (20) @(posedge REF_CLK);
        NRST <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        rd(RBSL_OFF_STATUS, {2'h0, 32'h3fff, 32'h1c00});
        wr(RBSL_OFF_POWER_CTRL, 32'h0);
        rd(RBSL_OFF_POWER_CTRL, {2'h0, 32'h1, 32'h0});
        rd(8'h40, {RBSL_RESP_SLVERR, 32'hffffffff, 32'h0});
        $display("status tests done");
        a = {4'h0, 12'($random(seed))};
        tbl(a, 1'b1, fq(a));
        cmd(RBSL_OP_CHIP_LOCK, 8'h0);
        tbl(a, 1'b1, RBSL_TABLE_LOCKED);
        tbl(a, 1'b0, fq(a));
        for (int i = 0; i < 5; i++) cmd(RBSL_OP_PAGE_SECURE, 8'(i));
        rd(RBSL_OFF_STATUS, {2'h0, 32'h1ff, 32'h1f1});
        tbl(a, 1'b0, RBSL_TABLE_LOCKED);
        cmd(RBSL_OP_READ, 8'h0, a, 2'b00);
        rd(RBSL_OFF_DATA, {2'h0, 32'hff00, 32'h5500});
        cmd(RBSL_OP_PRIMARY_ERASE, 8'h0);
        rd(RBSL_OFF_STATUS, {2'h0, 32'h1ff, 32'h101});
        tbl(a, 1'b0, fq(a));
        cmd(RBSL_OP_CHIP_LOCK, 8'h3);
        a = {4'h1, 12'($random(seed))};
        cmd(RBSL_OP_READ, 8'h0, a, 2'b11);
        rd(RBSL_OFF_STATUS, {2'h0, 32'h200f, 32'h2009});
        cmd(RBSL_OP_READ, 8'h0, a, 2'b01);
        rd(RBSL_OFF_DATA, {2'h0, 32'hff, 24'h0, fq(a)});
        cmd(RBSL_OP_CHIP_LOCK, 8'h1);
        cmd(RBSL_OP_READ, 8'h0, a, 2'b00);
        rd(RBSL_OFF_STATUS, {2'h0, 32'h200f, 32'h200b});
        cmd(RBSL_OP_IDENTITY_READ, 8'h0);
        rd(RBSL_OFF_DATA, {2'h0, 32'hff00, 16'h0, ID, 8'h0});
        cmd(RBSL_OP_CHIP_ERASE, 8'h0);
        rd(RBSL_OFF_STATUS, {2'h0, 32'h3fff, 32'h1800});
        $display("lock tests done");
        v = 8'($random(seed));
        cmd(RBSL_OP_SET_USER_VECTOR, v);
        cmd(RBSL_OP_SET_BOOT_BITS, 8'h2);
        EXTERNAL_ACCESS_PIN_N <= 1'b0;
        prst(30, RBSL_ZERO_ADDR);
        EXTERNAL_ACCESS_PIN_N <= 1'b1;
        STRAP_PIN_A <= 1'b0;
        STRAP_PIN_B <= 1'b0;
        prst(30, {2'b00, v, 6'h0});
        rd(RBSL_OFF_STATUS, {2'h0, 32'h200, 32'h200});
        STRAP_PIN_A <= 1'b1;
        prst(12, RBSL_ZERO_ADDR);
        cmd(RBSL_OP_SET_BOOT_BITS, 8'h1);
        prst(30, RBSL_ZERO_ADDR);
        cmd(RBSL_OP_SET_BOOT_BITS, 8'h3);
        cmd(RBSL_OP_CHIP_LOCK, 8'h2);
        EXTERNAL_ACCESS_PIN_N <= 1'b0;
        prst(30, DV);
        $display("boot tests done");
        complete_run();
    end
endmodule
